// ===== src/ssc_params.svh
// Constants for the spindle sync command block: offsets, codes, bit positions, reset values.
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH

`define SSC_AW             8
`define SSC_DW             32
`define SSC_OFF_CMD        8'h00
`define SSC_OFF_RESP       8'h04
`define SSC_OFF_STAT       8'h08
`define SSC_OFF_MASK       8'h0C
`define SSC_OFF_RESULT     8'h10
`define SSC_OFF_OFFSET     8'h14

`define SSC_BC_LOAD_FUNC   8'h01
`define SSC_BC_INDEX_OFS   8'h09
`define SSC_BC_READ_CFG    8'h41
`define SSC_BC_READ_STAT   8'h44
`define SSC_BC_READ_EXT    8'h48

`define SSC_FC_REF_OFF     8'h2E
`define SSC_FC_REF_ON      8'h2F
`define SSC_FC_TRANS_OFF   8'h30
`define SSC_FC_TRANS_ON    8'h31
`define SSC_FC_SYNC_OFF    8'h32
`define SSC_FC_SYNC_ON     8'h33
`define SSC_FC_RESYNC      8'h34

`define SSC_EV_W           5
`define SSC_EV_LOCK        0
`define SSC_EV_UNLOCK      1
`define SSC_EV_FAULT       2
`define SSC_EV_REJECT      3
`define SSC_EV_DONE        4

`define SSC_IN_W           6
`define SSC_IN_LOCK        0
`define SSC_IN_FAULT       1
`define SSC_IN_INDEX       2
`define SSC_IN_LOC_EN      3
`define SSC_IN_LOC_REF     4
`define SSC_IN_LOC_ALLOW   5

`define SSC_CFG_SYNC_SUP   1'b1
`define SSC_CFG_LOCAL_SUP  1'b1

`define SSC_RST_EV         5'h00
`define SSC_RST_OFS        16'h0000
`define SSC_RST_BIT        1'b0
`define SSC_RST_WORD       32'h0000_0000

`endif

// ===== src/ssc_pkg.sv
// Types shared by the spindle sync command block.
package ssc_pkg;

  typedef struct packed {
    logic [15:0] param;
    logic [7:0]  func;
    logic [7:0]  code;
  } ssc_cmd_s;

  typedef struct packed {
    logic local_en;
    logic locked;
    logic ref_src;
    logic ofs_active;
    logic trans_en;
    logic sync_en;
  } ssc_ext_s;

  typedef struct packed {
    logic local_sup;
    logic sync_sup;
  } ssc_cfg_s;

  typedef enum logic [1:0] {
    SSC_RES_IDLE,
    SSC_RES_DONE,
    SSC_RES_REJECT
  } ssc_res_e;

endpackage

// ===== src/ssc_sync_edge.sv
// Two-stage synchroniser bank with level and edge outputs.
`timescale 1ns/1ps
`include "ssc_params.svh"

module ssc_sync_edge (
  input  wire logic                 clk_sys, // System clock.
  input  wire logic                 resetn,  // Asynchronous reset, active low.
  input  wire logic [`SSC_IN_W-1:0] din,     // Asynchronous inputs.
  output logic      [`SSC_IN_W-1:0] lvl,     // Synchronised levels.
  output logic      [`SSC_IN_W-1:0] rise,    // One-cycle rising edge pulses.
  output logic      [`SSC_IN_W-1:0] fall     // One-cycle falling edge pulses.
);

  logic [`SSC_IN_W-1:0] meta_q;
  logic [`SSC_IN_W-1:0] lvl_q;
  logic [`SSC_IN_W-1:0] prev_q;

  genvar i;
  generate
    for (i = 0; i < `SSC_IN_W; i++) begin : g_bit
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          meta_q[i] <= `SSC_RST_BIT;
          lvl_q[i]  <= `SSC_RST_BIT;
          prev_q[i] <= `SSC_RST_BIT;
        end else begin
          meta_q[i] <= din[i];
          lvl_q[i]  <= meta_q[i];
          prev_q[i] <= lvl_q[i];
        end
      end
      assign rise[i] = lvl_q[i] & ~prev_q[i];
      assign fall[i] = ~lvl_q[i] & prev_q[i];
    end
  endgenerate

  assign lvl = lvl_q;

endmodule // ssc_sync_edge

// ===== src/ssc_top.sv
// Spindle sync command interpreter with register port, status events and interrupt.
//
// What this block does
// RULE_01: The master makes sure only one party in the string drives the sync reference.
// RULE_02: This slave can drive the sync reference from its own index when selected.
// RULE_03: Load slave function 01 with function 2E turns the reference off and 2F turns it on.
// RULE_04: Function 30 stops and function 31 starts reporting lock transitions as status.
// RULE_05: Function 32 stops following the reference, 33 locks to it, 34 forces a re-sync.
// RULE_06: Control 09 loads the index offset that delays this index against the reference.
// RULE_07: Read status 44 shows separate unlocked-to-locked and locked-to-unlocked bits.
// RULE_08: A spindle sync fault is reported to the master as a status condition.
// RULE_09: Read extended status 48 carries sync, transition, offset, source, lock and local flags.
// RULE_10: Read configuration 41 tells whether spindle sync and local sync are supported.
// RULE_11: Under local jumper control the same interrupt and status behaviour still applies.
// RULE_12: When local sync is switched on the local enabled flag is set in extended status.
// RULE_13: With local sync on, sync function codes are taken or refused by the local allow input.
// RULE_14: Transition events rise only while reporting is on; the locked flag tracks every change.
`timescale 1ns/1ps
`include "ssc_params.svh"

module ssc_top (
  input  wire logic                 clk_sys,        // System clock, 100 MHz.
  input  wire logic                 resetn,         // Asynchronous reset, active low.
  input  wire logic [`SSC_AW-1:0]   reg_addr,       // Register byte address.
  input  wire logic [`SSC_DW-1:0]   reg_wdata,      // Register write data.
  input  wire logic                 reg_wr,         // Write strobe.
  input  wire logic                 reg_rd,         // Read strobe.
  output logic      [`SSC_DW-1:0]   reg_rdata,      // Read data, cycle after strobe.
  output logic                      irq,            // Level interrupt.
  input  wire logic                 spin_locked,    // Servo reports spindle locked.
  input  wire logic                 spin_fault,     // Servo reports sync fault.
  input  wire logic                 spin_index,     // Own index pulse from spindle.
  input  wire logic                 local_sync_on,  // Local jumper: sync switched on.
  input  wire logic                 local_ref_on,   // Local jumper: act as reference.
  input  wire logic                 local_cmd_ok,   // Local mechanism allows sync commands.
  output logic                      sync_ref_out,   // Sync reference drive level.
  output logic                      sync_ref_oe,    // Sync reference drive enable.
  output logic                      sync_follow,    // Servo: follow the reference.
  output logic                      resync_pulse,   // Servo: one-cycle re-sync request.
  output logic      [15:0]          index_offset    // Servo: index angular offset.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisation.

  logic [`SSC_IN_W-1:0] in_lvl;
  logic [`SSC_IN_W-1:0] in_rise;
  logic [`SSC_IN_W-1:0] in_fall;

  ssc_sync_edge u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .din     ({local_cmd_ok, local_ref_on, local_sync_on, spin_index, spin_fault, spin_locked}),
    .lvl     (in_lvl),
    .rise    (in_rise),
    .fall    ()
  );

  logic lock_prev_q;
  logic lock_fall;
  assign lock_fall = ~in_lvl[`SSC_IN_LOCK] & lock_prev_q;

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  logic                   ref_en_q,   ref_en_d;
  logic                   trans_en_q, trans_en_d;
  logic                   sync_en_q,  sync_en_d;
  logic [15:0]            ofs_q,      ofs_d;
  logic [`SSC_EV_W-1:0]   stat_q,     stat_d;
  logic [`SSC_EV_W-1:0]   mask_q,     mask_d;
  logic [`SSC_DW-1:0]     resp_q,     resp_d;
  ssc_pkg::ssc_res_e      res_q,      res_d;
  logic [7:0]             last_q,     last_d;
  logic [`SSC_DW-1:0]     rdata_q,    rdata_d;
  logic                   resync_q,   resync_d;
  logic                   ref_out_q,  ref_out_d;
  logic                   ref_oe_q,   ref_oe_d;
  logic                   follow_q,   follow_d;

  ssc_pkg::ssc_cmd_s      cmd;
  ssc_pkg::ssc_ext_s      ext;
  ssc_pkg::ssc_cfg_s      cfg;
  logic [`SSC_EV_W-1:0]   ev;
  logic                   cmd_wr;
  logic                   local_en;
  logic                   eff_sync;
  logic                   eff_ref;
  logic                   accept;
  logic                   known;

  function automatic logic hit(input logic [`SSC_AW-1:0] a, input logic [`SSC_AW-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic is_sync_func(input logic [7:0] f);
    is_sync_func = (f >= `SSC_FC_REF_OFF) && (f <= `SSC_FC_RESYNC);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Effective control under local or command control.

  assign cmd      = ssc_pkg::ssc_cmd_s'(reg_wdata);
  assign cmd_wr   = reg_wr & hit(reg_addr, `SSC_OFF_CMD);
  assign local_en = in_lvl[`SSC_IN_LOC_EN];
  // Local jumpers force sync on; status and interrupts work the same either way.
  assign eff_sync = local_en | sync_en_q;                                        // [RULE_11]
  assign eff_ref  = local_en ? in_lvl[`SSC_IN_LOC_REF] : ref_en_q;               // [RULE_11]

  assign cfg.sync_sup  = `SSC_CFG_SYNC_SUP;                                      // [RULE_10]
  assign cfg.local_sup = `SSC_CFG_LOCAL_SUP;                                     // [RULE_10]

  assign ext.sync_en    = eff_sync;                                              // [RULE_09]
  assign ext.trans_en   = trans_en_q;                                            // [RULE_09]
  assign ext.ofs_active = eff_sync & (ofs_q != `SSC_RST_OFS);                    // [RULE_09]
  assign ext.ref_src    = eff_ref;                                               // [RULE_09]
  assign ext.locked     = in_lvl[`SSC_IN_LOCK];                                  // [RULE_14]
  assign ext.local_en   = local_en;                                              // [RULE_12]

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode.

  always_comb begin
    known = 1'b0;
    case (cmd.code)
      `SSC_BC_LOAD_FUNC: known = is_sync_func(cmd.func);
      `SSC_BC_INDEX_OFS,
      `SSC_BC_READ_CFG,
      `SSC_BC_READ_STAT,
      `SSC_BC_READ_EXT:  known = 1'b1;
      default:           known = 1'b0;
    endcase
  end

  // Sync function loads and index offset loads are refused while local sync is on and the local mechanism does not allow them.
  assign accept = known &
                  ~(local_en & ~in_lvl[`SSC_IN_LOC_ALLOW] &
                    ((cmd.code == `SSC_BC_LOAD_FUNC) |
                     (cmd.code == `SSC_BC_INDEX_OFS)));                          // [RULE_13]

  always_comb begin
    ref_en_d   = ref_en_q;
    trans_en_d = trans_en_q;
    sync_en_d  = sync_en_q;
    ofs_d      = ofs_q;
    resp_d     = resp_q;
    res_d      = res_q;
    last_d     = last_q;
    resync_d   = 1'b0;
    if (cmd_wr) begin
      last_d = cmd.code;
      res_d  = accept ? ssc_pkg::SSC_RES_DONE : ssc_pkg::SSC_RES_REJECT;
    end
    if (cmd_wr && accept) begin
      case (cmd.code)
        `SSC_BC_LOAD_FUNC: begin
          case (cmd.func)
            `SSC_FC_REF_OFF:   ref_en_d   = 1'b0;                                // [RULE_03]
            `SSC_FC_REF_ON:    ref_en_d   = 1'b1;                                // [RULE_03]
            `SSC_FC_TRANS_OFF: trans_en_d = 1'b0;                                // [RULE_04]
            `SSC_FC_TRANS_ON:  trans_en_d = 1'b1;                                // [RULE_04]
            `SSC_FC_SYNC_OFF:  sync_en_d  = 1'b0;                                // [RULE_05]
            `SSC_FC_SYNC_ON:   sync_en_d  = 1'b1;                                // [RULE_05]
            `SSC_FC_RESYNC:    resync_d   = 1'b1;                                // [RULE_05]
            default:           resync_d   = 1'b0;
          endcase
        end
        `SSC_BC_INDEX_OFS: ofs_d  = cmd.param;                                   // [RULE_06]
        `SSC_BC_READ_CFG:  resp_d = `SSC_DW'(cfg);                               // [RULE_10]
        `SSC_BC_READ_STAT: resp_d = `SSC_DW'(stat_q);                            // [RULE_07]
        `SSC_BC_READ_EXT:  resp_d = `SSC_DW'(ext);                               // [RULE_09]
        default:           resp_d = resp_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Events, interrupt status and mask.

  always_comb begin
    ev                 = `SSC_RST_EV;
    ev[`SSC_EV_LOCK]   = trans_en_q & in_rise[`SSC_IN_LOCK];                     // [RULE_14] [RULE_07]
    ev[`SSC_EV_UNLOCK] = trans_en_q & lock_fall;                                 // [RULE_14] [RULE_07]
    ev[`SSC_EV_FAULT]  = in_rise[`SSC_IN_FAULT];                                 // [RULE_08]
    ev[`SSC_EV_REJECT] = cmd_wr & ~accept;                                       // [RULE_13]
    ev[`SSC_EV_DONE]   = cmd_wr & accept;
  end

  always_comb begin
    stat_d = stat_q;
    mask_d = mask_q;
    if (reg_wr && hit(reg_addr, `SSC_OFF_STAT)) begin
      stat_d = stat_q & ~reg_wdata[`SSC_EV_W-1:0];
    end
    if (reg_wr && hit(reg_addr, `SSC_OFF_MASK)) begin
      mask_d = reg_wdata[`SSC_EV_W-1:0];
    end
    // A new event wins over a clear in the same cycle.
    stat_d = stat_d | ev;                                                        // [RULE_11]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reference drive and servo controls.

  always_comb begin
    ref_oe_d  = eff_ref;                                                         // [RULE_02]
    ref_out_d = eff_ref & in_lvl[`SSC_IN_INDEX];                                 // [RULE_02]
    follow_d  = eff_sync & ~eff_ref;                                             // [RULE_05]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register read port.

  always_comb begin
    rdata_d = `SSC_RST_WORD;
    if (reg_rd) begin
      case (reg_addr)
        `SSC_OFF_RESP:   rdata_d = resp_q;
        `SSC_OFF_STAT:   rdata_d = `SSC_DW'(stat_q);
        `SSC_OFF_MASK:   rdata_d = `SSC_DW'(mask_q);
        `SSC_OFF_RESULT: rdata_d = `SSC_DW'({last_q, 6'h00, res_q});
        `SSC_OFF_OFFSET: rdata_d = `SSC_DW'(ofs_q);
        default:         rdata_d = `SSC_RST_WORD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ref_en_q    <= `SSC_RST_BIT;
      trans_en_q  <= `SSC_RST_BIT;
      sync_en_q   <= `SSC_RST_BIT;
      ofs_q       <= `SSC_RST_OFS;
      stat_q      <= `SSC_RST_EV;
      mask_q      <= `SSC_RST_EV;
      resp_q      <= `SSC_RST_WORD;
      res_q       <= ssc_pkg::SSC_RES_IDLE;
      last_q      <= 8'h00;
      rdata_q     <= `SSC_RST_WORD;
      lock_prev_q <= `SSC_RST_BIT;
      resync_q    <= `SSC_RST_BIT;
      ref_out_q   <= `SSC_RST_BIT;
      ref_oe_q    <= `SSC_RST_BIT;
      follow_q    <= `SSC_RST_BIT;
    end else begin
      ref_en_q    <= ref_en_d;
      trans_en_q  <= trans_en_d;
      sync_en_q   <= sync_en_d;
      ofs_q       <= ofs_d;
      stat_q      <= stat_d;
      mask_q      <= mask_d;
      resp_q      <= resp_d;
      res_q       <= res_d;
      last_q      <= last_d;
      rdata_q     <= rdata_d;
      lock_prev_q <= in_lvl[`SSC_IN_LOCK];
      resync_q    <= resync_d;
      ref_out_q   <= ref_out_d;
      ref_oe_q    <= ref_oe_d;
      follow_q    <= follow_d;
    end
  end

  assign reg_rdata    = rdata_q;
  assign irq          = |(stat_q & mask_q);
  assign sync_ref_out = ref_out_q;
  assign sync_ref_oe  = ref_oe_q;                                                // [RULE_01]
  assign sync_follow  = follow_q;
  assign resync_pulse = resync_q;
  assign index_offset = ofs_q;

endmodule // ssc_top

// ===== tb/ssc_top_properties.sv
// Concurrent checks on the ports of the spindle sync command block.
`timescale 1ns/1ps
`include "ssc_params.svh"

module ssc_top_properties (
  input wire logic               clk_sys,       // System clock.
  input wire logic               resetn,        // Reset, active low.
  input wire logic [`SSC_AW-1:0] reg_addr,      // Register address.
  input wire logic [`SSC_DW-1:0] reg_wdata,     // Write data.
  input wire logic               reg_wr,        // Write strobe.
  input wire logic               reg_rd,        // Read strobe.
  input wire logic [`SSC_DW-1:0] reg_rdata,     // Read data.
  input wire logic               irq,           // Interrupt.
  input wire logic               local_sync_on, // Local sync jumper.
  input wire logic               sync_ref_out,  // Reference drive level.
  input wire logic               sync_ref_oe,   // Reference drive enable.
  input wire logic               sync_follow,   // Follow request.
  input wire logic               resync_pulse,  // Re-sync pulse.
  input wire logic [15:0]        index_offset   // Index offset.
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [2:0] loc_q;
  logic       quiet;
  logic       cmd_wr;
  logic       rs_wr;
  // Commands are only predictable once the local jumper has been low long enough to sync.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      loc_q <= 3'h7;
    end else begin
      loc_q <= {loc_q[1:0], local_sync_on};
    end
  end
  assign quiet  = (loc_q == 3'h0) && !local_sync_on;
  assign cmd_wr = reg_wr && (reg_addr == `SSC_OFF_CMD) && quiet;
  assign rs_wr  = reg_wr && (reg_addr == `SSC_OFF_CMD) && (reg_wdata[15:0] == 16'h3401);
  ////////////////////////////////////////////////////////////////////////////
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == '0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
  property p_cmd_wo; reg_rd && reg_addr == `SSC_OFF_CMD |=> reg_rdata == '0; endproperty
  a_cmd_wo: assert property (p_cmd_wo) else $error("command word readable");
  property p_unmap; reg_rd && reg_addr > `SSC_OFF_OFFSET |=> reg_rdata == '0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_ref_on;
    cmd_wr && reg_wdata[15:0] == 16'h2F01 |=> ##1 sync_ref_oe;
  endproperty
  a_ref_on: assert property (p_ref_on) else $error("reference drive not enabled");
  property p_ref_off;
    cmd_wr && reg_wdata[15:0] == 16'h2E01 |=> ##1 !sync_ref_oe;
  endproperty
  a_ref_off: assert property (p_ref_off) else $error("reference drive not off");
  property p_offset;
    cmd_wr && reg_wdata[7:0] == `SSC_BC_INDEX_OFS |=> ##1 index_offset == $past(reg_wdata[31:16], 2);
  endproperty
  a_offset: assert property (p_offset) else $error("index offset not loaded");
  property p_resync; resync_pulse |-> $past(rs_wr) ##1 !resync_pulse; endproperty
  a_resync: assert property (p_resync) else $error("stray or long re-sync pulse");
  property p_irq_mask0; reg_wr && reg_addr == `SSC_OFF_MASK && reg_wdata == '0 |=> !irq; endproperty
  a_irq_mask0: assert property (p_irq_mask0) else $error("interrupt while masked");
  property p_follow_excl; sync_ref_oe |-> !sync_follow; endproperty
  a_follow_excl: assert property (p_follow_excl) else $error("source also follows");
  property p_out_idle; !sync_ref_oe |-> !sync_ref_out; endproperty
  a_out_idle: assert property (p_out_idle) else $error("reference driven while off");
  c_ref: cover property ($rose(sync_ref_oe));
  c_irq: cover property ($rose(irq));
  c_resync: cover property (resync_pulse);
endmodule // ssc_top_properties

bind ssc_top ssc_top_properties u_props (.*);

// ===== tb/ssc_servo_model.sv
// Behavioural spindle servo that answers the follow and re-sync requests of the block.
`timescale 1ns/1ps

module ssc_servo_model #(
  parameter int LOCK_DLY = 20 // Cycles of following before lock.
) (
  input  wire logic clk_sys,      // System clock.
  input  wire logic resetn,       // Reset, active low.
  input  wire logic sync_follow,  // Follow request.
  input  wire logic resync_pulse, // Re-sync request.
  input  wire logic flt_req,      // Bench asks for a fault.
  output logic      spin_locked,  // Lock level.
  output logic      spin_fault,   // Fault level.
  output logic      spin_index    // Index pulse.
);
  int         cnt;
  logic [3:0] ph;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      ph <= 4'h0;
      spin_locked <= 1'b0;
      spin_index <= 1'b0;
      spin_fault <= 1'b0;
    end else begin
      ph <= ph + 4'h1;
      spin_index <= (ph == 4'h0);
      spin_fault <= flt_req;
      // A re-sync throws the lock away and the servo must settle again.
      if (!sync_follow || resync_pulse) begin
        cnt <= 0;
      end else if (cnt < LOCK_DLY) begin
        cnt <= cnt + 1;
      end
      spin_locked <= (cnt == LOCK_DLY) && sync_follow && !resync_pulse;
    end
  end
endmodule // ssc_servo_model

// ===== tb/testbench.sv
// Self-checking bench for the spindle sync command block.
`timescale 1ns/1ps
`include "ssc_params.svh"

module testbench;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        irq, spin_locked, spin_fault, spin_index;
  logic        local_sync_on = 1'b0;
  logic        local_ref_on = 1'b0;
  logic        local_cmd_ok = 1'b0;
  logic        flt_req = 1'b0;
  logic        sync_ref_out, sync_ref_oe, sync_follow, resync_pulse;
  logic [15:0] index_offset;
  logic [31:0] d;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [31:0] row_cmd [10] = '{32'h0000_2F01, 32'h0000_2E01, 32'h0000_3101, 32'h0000_3001,
    32'h0000_3301, 32'h0000_3201, 32'h0000_3401, 32'h1234_0009, 32'h0000_3501, 32'h0000_0077};
  logic [9:0]  row_acc = 10'b00_1111_1111;

  always #5 clk_sys = ~clk_sys;

  ssc_top u_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .spin_locked(spin_locked), .spin_fault(spin_fault), .spin_index(spin_index),
    .local_sync_on(local_sync_on), .local_ref_on(local_ref_on), .local_cmd_ok(local_cmd_ok),
    .sync_ref_out(sync_ref_out), .sync_ref_oe(sync_ref_oe), .sync_follow(sync_follow),
    .resync_pulse(resync_pulse), .index_offset(index_offset));

  ssc_servo_model u_srv (.clk_sys(clk_sys), .resetn(resetn), .sync_follow(sync_follow),
    .resync_pulse(resync_pulse), .flt_req(flt_req), .spin_locked(spin_locked),
    .spin_fault(spin_fault), .spin_index(spin_index));

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    #1 chk(irq, 1'b0);
    chk(sync_ref_oe, 1'b0);
    for (int a = 0; a <= 32; a += 4) begin
      rd(8'(a), d);
      chk(d, 32'h0000_0000);
    end
    for (int i = 0; i < 10; i++) begin
      wr(`SSC_OFF_CMD, row_cmd[i]);
      rd(`SSC_OFF_RESULT, d);
      chk(d, {16'h0000, row_cmd[i][7:0], 6'h00, row_acc[i] ? 2'h1 : 2'h2});
    end
    rd(`SSC_OFF_STAT, d);
    chk(d, 32'h0000_0018);
    rd(`SSC_OFF_OFFSET, d);
    chk(d, 32'h0000_1234);
    chk(index_offset, 32'h0000_1234);
    wr(`SSC_OFF_STAT, 32'h0000_001F);
    wr(`SSC_OFF_CMD, 32'h0000_3101);
    wr(`SSC_OFF_CMD, 32'h0000_3301);
    repeat (60) @(posedge clk_sys);
    rd(`SSC_OFF_STAT, d);
    chk(d, 32'h0000_0011);
    wr(`SSC_OFF_CMD, 32'h0000_0048);
    rd(`SSC_OFF_RESP, d);
    chk(d, 32'h0000_0017);
    wr(`SSC_OFF_STAT, 32'h0000_001F);
    wr(`SSC_OFF_CMD, 32'h0000_3401);
    repeat (60) @(posedge clk_sys);
    wr(`SSC_OFF_CMD, 32'h0000_0044);
    rd(`SSC_OFF_RESP, d);
    chk(d, 32'h0000_0013);
    wr(`SSC_OFF_CMD, 32'h0000_0041);
    rd(`SSC_OFF_RESP, d);
    chk(d, 32'h0000_0003);
    wr(`SSC_OFF_STAT, 32'h0000_001F);
    wr(`SSC_OFF_CMD, 32'h0000_3001);
    wr(`SSC_OFF_CMD, 32'h0000_3401);
    repeat (60) @(posedge clk_sys);
    rd(`SSC_OFF_STAT, d);
    chk(d, 32'h0000_0010);
    wr(`SSC_OFF_MASK, 32'h0000_0004);
    #1 chk(irq, 1'b0);
    flt_req <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 chk(irq, 1'b1);
    rd(`SSC_OFF_STAT, d);
    chk(d, 32'h0000_0014);
    wr(`SSC_OFF_STAT, 32'h0000_0004);
    #1 chk(irq, 1'b0);
    flt_req <= 1'b0;
    wr(`SSC_OFF_MASK, 32'h0000_0000);
    // The master keeps this slave as the only reference source.
    wr(`SSC_OFF_CMD, 32'h0000_2F01);
    @(posedge clk_sys);
    #1 chk(sync_ref_oe, 1'b1);
    chk(sync_follow, 1'b0);
    wr(`SSC_OFF_CMD, 32'h0000_0048);
    rd(`SSC_OFF_RESP, d);
    chk(d & 32'h0000_002F, 32'h0000_000D);
    wr(`SSC_OFF_CMD, 32'h0000_2E01);
    local_sync_on <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wr(`SSC_OFF_CMD, 32'h0000_3201);
    rd(`SSC_OFF_RESULT, d);
    chk(d[1:0], 2'h2);
    wr(`SSC_OFF_CMD, 32'h0000_0048);
    rd(`SSC_OFF_RESP, d);
    chk(d[5], 1'b1);
    chk(sync_follow, 1'b1);
    local_cmd_ok <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wr(`SSC_OFF_CMD, 32'h0000_3201);
    rd(`SSC_OFF_RESULT, d);
    chk(d[1:0], 2'h1);
    close_out();
  end
endmodule // testbench
